/* arw_pkg.sv */
// arw_pkg: constants, types and register map of the converter result
// window register block.
// assumes: one 32-bit AHB-Lite slave, each register in one aligned word.
package arw_pkg;

    // ----------------------------------------------------------------
    // register word indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [5:0] ARW_IDX_CTRL = 6'h04;
    localparam logic [5:0] ARW_IDX_MASK = 6'h0A;
    localparam logic [5:0] ARW_IDX_FLAGS = 6'h0B;
    localparam logic [5:0] ARW_IDX_DBG = 6'h0C;
    localparam logic [5:0] ARW_IDX_TEMP = 6'h0D;
    localparam logic [5:0] ARW_IDX_RES_LO = 6'h10;
    localparam logic [5:0] ARW_IDX_RES_HI = 6'h11;
    localparam logic [5:0] ARW_IDX_WLT_LO = 6'h12;
    localparam logic [5:0] ARW_IDX_WLT_HI = 6'h13;
    localparam logic [5:0] ARW_IDX_WHT_LO = 6'h14;
    localparam logic [5:0] ARW_IDX_WHT_HI = 6'h15;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int ARW_CTRL_MODE_LSB = 0;
    localparam int ARW_CTRL_ACC_LSB = 4;
    localparam int ARW_DBG_RUN_BIT = 0;
    localparam int ARW_FLAG_RDY = 0;
    localparam int ARW_FLAG_WIN = 1;
    localparam logic [7:0] ARW_RST_BYTE = 8'h00;
    localparam logic [15:0] ARW_RST_WORD = 16'h0000;
    localparam logic [2:0] ARW_ACC_LOG2_MAX = 3'h6;
    localparam logic [9:0] ARW_SAMPLE_MAX = 10'h3FF;
    localparam logic [15:0] ARW_ACC_MAX = 16'hFFC0;
    localparam logic [1:0] ARW_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] ARW_RESP_OKAY = 2'h0;

    // window comparison modes
    typedef enum logic [2:0] {
        ARW_WIN_NONE = 3'h0,
        ARW_WIN_BELOW = 3'h1,
        ARW_WIN_ABOVE = 3'h2,
        ARW_WIN_INSIDE = 3'h3,
        ARW_WIN_OUTSIDE = 3'h4
    } arw_win_mode_t;

    // ahb-lite master side of one transfer, hready included
    typedef struct packed {
        logic hsel;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] haddr;
        logic [31:0] hwdata;
        logic hready;
    } arw_ahb_req_t;

    // one raw conversion from the analog core, two's complement
    typedef struct packed {
        logic valid;
        logic signed [11:0] raw;
    } arw_sample_t;

endpackage : arw_pkg

/* arw_regs.sv */
// arw_regs: software view of the converter result, accumulation,
// window comparator, debug run control and shared byte latch.
// assumes: single clock, synchronous reset, zero-wait AHB-Lite slave,
// conversion core hands over one raw sample per valid pulse.
//
// Summary of operation
// RULE1 - halted without debug run: stop, ignore events
// RULE2 - debug run set: keep running while halted
// RULE3 - one shared 8-bit byte latch, read/write
// RULE4 - result low byte at base, high next
// RULE5 - single sample saturates to 0x000..0x3FF
// RULE6 - accumulated result never exceeds 0xFFC0
// RULE7 - unsigned magnitude, 0x0000 zero, 0xFFFF full; code: full is 0x3FF single, 0xFFC0 accumulated
// RULE8 - single result in ten low bits
// RULE9 - window compared once on final accumulation
// RULE10 - 16-bit low threshold at 0x12, 0x13
// RULE11 - result read or write-one clears flags
// RULE12 - window modes none, below, above, inside, outside
// RULE13 - 16-bit high threshold at 0x14, 0x15
// RULE14 - low read latches high; high write commits
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps

module arw_regs (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire arw_pkg::arw_ahb_req_t ahb_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire arw_pkg::arw_sample_t sample_i,
    input wire logic start_event_i,
    input wire logic cpu_halted_i,
    output logic start_conv_o,
    output logic run_enable_o,
    output logic irq_o
);
    import arw_pkg::*;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // clamp a raw sample into the ten-bit range
    function automatic logic [9:0] sat10(input logic signed [11:0] raw);
        logic [9:0] r;
        r = raw[9:0];
        if (raw < 12'sh000) begin
            r = 10'h000;
        end else if (raw > 12'sh3FF) begin
            r = ARW_SAMPLE_MAX;
        end
        return r;
    endfunction : sat10

    // unsigned window check of a finished result
    function automatic logic win_match(input logic [2:0] mode,
                                       input logic [15:0] res,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
        logic m;
        m = 1'b0;
        case (mode)
            ARW_WIN_BELOW: begin
                m = res < lo;
            end
            ARW_WIN_ABOVE: begin
                m = res > hi;
            end
            ARW_WIN_INSIDE: begin
                m = (res > lo) && (res < hi);
            end
            ARW_WIN_OUTSIDE: begin
                m = (res < lo) || (res > hi);
            end
            default: begin
                m = 1'b0;
            end
        endcase
        return m;
    endfunction : win_match

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [1:0] mask_q;
    logic [1:0] flags_q;
    logic [1:0] flags_d;
    logic dbg_run_q;
    logic [7:0] temp_q;
    logic [7:0] temp_d;
    logic [15:0] result_q;
    logic [15:0] window_low_threshold_q;
    logic [15:0] window_high_threshold_q;
    logic [15:0] acc_q;
    logic [6:0] cnt_q;
    logic wr_pend_q;
    logic [5:0] wr_idx_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic addr_ok;
    logic acc_phase;
    logic rd_en;
    logic [5:0] rd_idx;
    logic wr_en;
    logic [7:0] wbyte;
    logic [31:0] rd_word;

    // address phase taken while hready is high
    assign addr_ok = ahb_i.haddr[31:8] == 24'h000000;
    assign acc_phase = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
    assign rd_en = acc_phase && !ahb_i.hwrite && addr_ok;
    assign rd_idx = ahb_i.haddr[7:2];
    assign wr_en = wr_pend_q && ahb_i.hready;
    assign wbyte = ahb_i.hwdata[7:0];

    // read mux, high halves come from the shared latch
    always_comb begin
        rd_word = 32'h00000000;
        case (rd_idx)
            ARW_IDX_CTRL: rd_word[7:0] = ctrl_q;
            ARW_IDX_MASK: rd_word[1:0] = mask_q;
            ARW_IDX_FLAGS: rd_word[1:0] = flags_q;
            ARW_IDX_DBG: rd_word[ARW_DBG_RUN_BIT] = dbg_run_q;
            ARW_IDX_TEMP: rd_word[7:0] = temp_q; // see RULE3
            ARW_IDX_RES_LO: rd_word[7:0] = result_q[7:0]; // see RULE4
            ARW_IDX_RES_HI: rd_word[7:0] = temp_q; // see RULE4
            ARW_IDX_WLT_LO: rd_word[7:0] = window_low_threshold_q[7:0];
            ARW_IDX_WLT_HI: rd_word[7:0] = temp_q;
            ARW_IDX_WHT_LO: rd_word[7:0] = window_high_threshold_q[7:0];
            ARW_IDX_WHT_HI: rd_word[7:0] = temp_q;
            default: rd_word = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // debug run control
    // ----------------------------------------------------------------
    logic freeze;
    logic take;
    logic [2:0] mode;
    logic [2:0] acc_log2;

    assign freeze = cpu_halted_i && !dbg_run_q; // see RULE1
    assign take = sample_i.valid && !freeze; // see RULE1 see RULE2
    assign mode = ctrl_q[ARW_CTRL_MODE_LSB +: 3];
    assign acc_log2 = (ctrl_q[ARW_CTRL_ACC_LSB +: 3] > ARW_ACC_LOG2_MAX) ?
        ARW_ACC_LOG2_MAX : ctrl_q[ARW_CTRL_ACC_LSB +: 3];

    // ----------------------------------------------------------------
    // accumulation and window comparison
    // ----------------------------------------------------------------
    logic [9:0] sample10;
    logic [15:0] acc_sum;
    logic [6:0] cnt_next;
    logic [6:0] cnt_target;
    logic last;
    logic set_rdy;
    logic set_win;

    // unsigned magnitude, sample in the ten low bits
    assign sample10 = sat10(sample_i.raw); // see RULE5 see RULE7
    assign acc_sum = acc_q + {6'h00, sample10}; // see RULE8 see RULE6
    assign cnt_next = cnt_q + 7'h01;
    assign cnt_target = 7'h01 << acc_log2;
    assign last = cnt_next >= cnt_target;
    assign set_rdy = take && last;
    // only the finished sum is compared
    assign set_win = set_rdy &&
        win_match(mode, acc_sum, window_low_threshold_q, window_high_threshold_q); // see RULE9 see RULE12

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_q <= ARW_RST_WORD;
            cnt_q <= 7'h00;
            result_q <= ARW_RST_WORD;
        end else if (take) begin
            acc_q <= last ? ARW_RST_WORD : acc_sum;
            cnt_q <= last ? 7'h00 : cnt_next;
            if (last) begin
                result_q <= acc_sum;
            end
        end
    end

    // ----------------------------------------------------------------
    // flags: result read or write-one clears, set wins
    // ----------------------------------------------------------------
    logic rd_res;
    logic [1:0] w1c;
    logic [1:0] set_vec;

    assign rd_res = rd_en &&
        (rd_idx == ARW_IDX_RES_LO || rd_idx == ARW_IDX_RES_HI);
    assign w1c = (wr_en && wr_idx_q == ARW_IDX_FLAGS) ? wbyte[1:0] : 2'h0;
    assign set_vec = {set_win, set_rdy};
    assign flags_d = set_vec |
        (flags_q & ~w1c & ~{2{rd_res}}); // see RULE11

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flags_q <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_o <= |(flags_d & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // shared byte latch
    // ----------------------------------------------------------------
    logic wr_to_temp;
    logic rd_lo;
    logic [7:0] rd_hi_byte;

    assign wr_to_temp = wr_en && (wr_idx_q == ARW_IDX_TEMP ||
        wr_idx_q == ARW_IDX_WLT_LO || wr_idx_q == ARW_IDX_WHT_LO);
    assign rd_lo = rd_en && (rd_idx == ARW_IDX_RES_LO ||
        rd_idx == ARW_IDX_WLT_LO || rd_idx == ARW_IDX_WHT_LO);
    assign rd_hi_byte = (rd_idx == ARW_IDX_RES_LO) ? result_q[15:8] :
        (rd_idx == ARW_IDX_WLT_LO) ? window_low_threshold_q[15:8] : window_high_threshold_q[15:8];

    // the later transfer (read in address phase) wins
    always_comb begin
        temp_d = temp_q;
        if (wr_to_temp) begin
            temp_d = wbyte; // see RULE14
        end
        if (rd_lo) begin
            temp_d = rd_hi_byte; // see RULE14
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            temp_q <= ARW_RST_BYTE;
        end else begin
            temp_q <= temp_d; // see RULE3
        end
    end

    // ----------------------------------------------------------------
    // software registers, written in the data phase
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_q <= ARW_RST_BYTE;
            mask_q <= 2'h0;
            dbg_run_q <= 1'b0;
            window_low_threshold_q <= ARW_RST_WORD;
            window_high_threshold_q <= ARW_RST_WORD;
        end else if (wr_en) begin
            case (wr_idx_q)
                ARW_IDX_CTRL: ctrl_q <= wbyte;
                ARW_IDX_MASK: mask_q <= wbyte[1:0];
                ARW_IDX_DBG: dbg_run_q <= wbyte[ARW_DBG_RUN_BIT];
                ARW_IDX_WLT_HI: window_low_threshold_q <= {wbyte, temp_q}; // see RULE10
                ARW_IDX_WHT_HI: window_high_threshold_q <= {wbyte, temp_q}; // see RULE13
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus pipeline and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 6'h00;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            start_conv_o <= 1'b0;
            run_enable_o <= 1'b1;
        end else begin
            if (ahb_i.hready) begin
                wr_pend_q <= acc_phase && ahb_i.hwrite && addr_ok;
                wr_idx_q <= rd_idx;
            end
            if (rd_en) begin
                hrdata_o <= rd_word;
            end
            hreadyout_o <= 1'b1;
            hresp_o <= ARW_RESP_OKAY[0];
            start_conv_o <= start_event_i && !freeze; // see RULE1
            run_enable_o <= !freeze; // see RULE2
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence rd_res_lo_s;
        rd_en && rd_idx == ARW_IDX_RES_LO;
    endsequence

    sequence rd_res_hi_s;
        rd_en && rd_idx == ARW_IDX_RES_HI;
    endsequence

    AST_FREEZE_STOPS: assert property (@(posedge mclk_i) disable iff (srst_i)
        freeze |=> !start_conv_o && !run_enable_o) // see RULE1
        else $error("core kept running while halted");

    AST_DEBUG_RUN: assert property (@(posedge mclk_i) disable iff (srst_i)
        start_event_i && cpu_halted_i && dbg_run_q |=> start_conv_o)
        else $error("event dropped with debug run set"); // see RULE2

    AST_TEMP_LATCH: assert property (@(posedge mclk_i) disable iff (srst_i)
        rd_res_lo_s |=> temp_q == $past(result_q[15:8])) // see RULE3
        else $error("low read did not latch high byte");

    AST_RES_PAIR: assert property (@(posedge mclk_i) disable iff (srst_i)
        rd_res_lo_s ##1 (!take && !wr_to_temp && !rd_lo) [*2] // see RULE4
        ##0 rd_res_hi_s |=> hrdata_o[7:0] == $past(result_q[15:8], 3))
        else $error("result high byte mismatch");

    AST_SINGLE_SAT: assert property (@(posedge mclk_i) disable iff (srst_i)
        set_rdy && acc_log2 == 3'h0 |=> result_q <= 16'h03FF) // see RULE5
        else $error("single result above ten bits");

    AST_ACC_LIMIT: assert property (@(posedge mclk_i) disable iff (srst_i)
        result_q <= ARW_ACC_MAX) // see RULE6
        else $error("accumulated result above limit");

    AST_WIN_ONCE: assert property (@(posedge mclk_i) disable iff (srst_i)
        take && !last && !flags_q[ARW_FLAG_WIN] |=> !flags_q[ARW_FLAG_WIN])
        else $error("window checked on a partial sum"); // see RULE9

    AST_WLT_COMMIT: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr_en && wr_idx_q == ARW_IDX_WLT_HI
        |=> window_low_threshold_q == {$past(wbyte), $past(temp_q)}) // see RULE10
        else $error("low threshold not committed");

    AST_RD_CLEARS: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rd_res_lo_s and !take) |=> flags_q == 2'h0) // see RULE11
        else $error("result read left a flag set");

    AST_SET_WINS: assert property (@(posedge mclk_i) disable iff (srst_i)
        set_rdy |=> flags_q[ARW_FLAG_RDY]) // see RULE11
        else $error("ready flag lost against clear");

    AST_BELOW: assert property (@(posedge mclk_i) disable iff (srst_i)
        set_win && mode == ARW_WIN_BELOW |-> acc_sum < window_low_threshold_q) // see RULE12
        else $error("below match without cause");

    AST_WHT_COMMIT: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr_en && wr_idx_q == ARW_IDX_WHT_HI
        |=> window_high_threshold_q == {$past(wbyte), $past(temp_q)}) // see RULE13
        else $error("high threshold not committed");

    AST_IRQ: assert property (@(posedge mclk_i) disable iff (srst_i)
        ##1 irq_o == |($past(flags_d) & $past(mask_q)))
        else $error("interrupt does not follow flags");

endmodule : arw_regs

/* arw_cpu_model.sv */
// arw_cpu_model: software side of the register bus, one word a transfer.
// assumes: one AHB-Lite slave whose ready is fed back on hready_i.
`timescale 1ns/100ps

module arw_cpu_model (
    input wire logic mclk_i,
    input wire logic hready_i,
    output arw_pkg::arw_ahb_req_t ahb_o
);
    import arw_pkg::*;

    // ----------------------------------------------------------------
    // request lines
    // ----------------------------------------------------------------
    arw_ahb_req_t req_q;
    int hang_count;

    // the shared ready travels with the request
    always_comb begin
        ahb_o = req_q;
        ahb_o.hready = hready_i;
    end

    initial begin
        req_q = '0;
        hang_count = 0;
    end

    // ----------------------------------------------------------------
    // transfer tasks
    // ----------------------------------------------------------------
    // wait for ready at a rising edge, bounded so a stuck slave is seen
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (hready_i !== 1'b1 && n < 64);
        if (n >= 64) begin
            hang_count++;
        end
    endtask : wait_rdy

    // single word: address phase held to ready, then data phase
    task automatic xfer(input logic wr, input logic [5:0] idx,
                        input logic [7:0] wd);
        req_q.hsel <= 1'b1;
        req_q.htrans <= ARW_HTRANS_NONSEQ;
        req_q.hwrite <= wr;
        req_q.hsize <= 3'h2;
        req_q.haddr <= {24'h000000, idx, 2'h0};
        wait_rdy();
        req_q.htrans <= 2'h0;
        req_q.hwdata <= {24'h000000, wd};
        wait_rdy();
    endtask : xfer
endmodule : arw_cpu_model

/* adc_result_window_regs_tb_top.sv */
// testbench: drives bus, samples, events and halt into arw_regs.
// assumes: zero-wait slave; read expectations queued, checked by monitor.
`timescale 1ns/100ps

module adc_result_window_regs_tb_top;
    import arw_pkg::*;
    logic mclk_i, srst_i, start_event_i, cpu_halted_i;
    arw_ahb_req_t ahb;
    arw_sample_t smp;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, start_conv_o, run_enable_o, irq_o;
    int err_count, total_checks;
    logic [31:0] exp_q[$];
    logic rd_pend;
    logic [15:0] sum;
    logic [11:0] raw;
    logic [5:0] rst_idx [7] = '{ARW_IDX_DBG, ARW_IDX_TEMP, ARW_IDX_RES_LO,
        ARW_IDX_RES_HI, ARW_IDX_WLT_LO, ARW_IDX_WLT_HI, 6'h3F};
    logic [11:0] vals [5] = '{12'h0FF, 12'h100, 12'h150, 12'h200, 12'h250};

    arw_regs dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .ahb_i(ahb),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .sample_i(smp), .start_event_i(start_event_i),
        .cpu_halted_i(cpu_halted_i), .start_conv_o(start_conv_o),
        .run_enable_o(run_enable_o), .irq_o(irq_o));
    arw_cpu_model cpu_u (.mclk_i(mclk_i), .hready_i(hreadyout_o),
        .ahb_o(ahb));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        err_count += cpu_u.hang_count + exp_q.size();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        cpu_u.xfer(1'b0, idx, 8'h00);
    endtask : rd

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        cpu_u.xfer(1'b1, idx, d);
    endtask : wr

    // low byte first, the high byte commits the pair
    task automatic wr16(input logic [5:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 6'h01, v[15:8]);
    endtask : wr16

    task automatic rd16(input logic [5:0] idx, input logic [15:0] v);
        rd(idx, {24'h000000, v[7:0]});
        rd(idx + 6'h01, {24'h000000, v[15:8]});
    endtask : rd16

    task automatic samp(input logic [11:0] r);
        smp <= '{valid: 1'b1, raw: r};
        @(posedge mclk_i);
        smp.valid <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask : samp

    // single-bit outputs: 0 irq, 1 run, 2 start, 3 resp, 4 ready
    logic [4:0] obs;
    assign obs = {hreadyout_o, hresp_o, start_conv_o, run_enable_o, irq_o};

    // look mid-cycle where outputs have settled, resume at a rising edge
    task automatic ckbit(input int b, input logic e);
        @(negedge mclk_i);
        check({31'h0, obs[b]}, {31'h0, e});
        @(posedge mclk_i);
    endtask : ckbit

    task automatic pulse;
        start_event_i <= 1'b1;
        @(posedge mclk_i);
        start_event_i <= 1'b0;
    endtask : pulse

    function automatic logic [15:0] clamp(input logic [11:0] r);
        if (r[11]) return 16'h0000;
        if (r > 12'h3FF) return 16'h03FF;
        return {4'h0, r};
    endfunction : clamp

    function automatic logic hit(input int m, input logic [15:0] r);
        case (m)
            1: return r < 16'h0100;
            2: return r > 16'h0200;
            3: return r > 16'h0100 && r < 16'h0200;
            4: return r < 16'h0100 || r > 16'h0200;
            default: return 1'b0;
        endcase
    endfunction : hit

    // read data checked at the edge that ends each read data phase
    always @(posedge mclk_i) begin
        if (rd_pend && exp_q.size() > 0) begin
            check(hrdata_o, exp_q.pop_front());
        end
        rd_pend = ahb.hsel & ahb.htrans[1] & ~ahb.hwrite & ahb.hready;
    end

    initial begin
        repeat (100000) @(posedge mclk_i);
        err_count++;
        conclude();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        srst_i = 1'b1;
        start_event_i = 1'b0;
        cpu_halted_i = 1'b0;
        smp = '0;
        err_count = 0;
        total_checks = 0;
        rd_pend = 1'b0;
        void'($urandom(32'h9D17));
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        foreach (rst_idx[i]) rd(rst_idx[i], 32'h0);
        ckbit(3, 1'b0);
        ckbit(4, 1'b1);
        wr16(ARW_IDX_WLT_LO, 16'h1234);
        rd16(ARW_IDX_WLT_LO, 16'h1234);
        rd(ARW_IDX_TEMP, 32'h12);
        wr(ARW_IDX_TEMP, 8'h5A);
        rd(ARW_IDX_TEMP, 32'h5A);
        samp(12'h7FF);
        rd16(ARW_IDX_RES_LO, 16'h03FF);
        samp(12'h800);
        rd16(ARW_IDX_RES_LO, 16'h0000);
        wr(ARW_IDX_CTRL, 8'h20);
        sum = 16'h0000;
        repeat (4) begin
            raw = 12'($urandom);
            sum += clamp(raw);
            samp(raw);
        end
        rd16(ARW_IDX_RES_LO, sum);
        wr(ARW_IDX_CTRL, 8'h60);
        repeat (64) samp(12'h7FF);
        rd(ARW_IDX_FLAGS, 32'h1);
        rd16(ARW_IDX_RES_LO, 16'hFFC0);
        wr16(ARW_IDX_WLT_LO, 16'h0100);
        wr16(ARW_IDX_WHT_LO, 16'h0200);
        wr(ARW_IDX_CTRL, 8'h21);
        repeat (3) samp(12'h060);
        rd(ARW_IDX_FLAGS, 32'h0);
        samp(12'h060);
        rd(ARW_IDX_FLAGS, 32'h1);
        rd16(ARW_IDX_RES_LO, 16'h0180);
        for (int m = 0; m < 6; m++) begin // code 5 reserved: no match
            for (int k = 0; k < 5; k++) begin
                wr(ARW_IDX_CTRL, 8'(m));
                samp(vals[k]);
                rd(ARW_IDX_FLAGS, {30'h0, hit(m, {4'h0, vals[k]}), 1'b1});
                rd16(ARW_IDX_RES_LO, {4'h0, vals[k]});
                rd(ARW_IDX_FLAGS, 32'h0);
            end
        end
        wr(ARW_IDX_CTRL, 8'h00);
        wr(ARW_IDX_MASK, 8'h01);
        samp(12'h010);
        ckbit(0, 1'b1);
        wr(ARW_IDX_FLAGS, 8'h00);
        @(posedge mclk_i);
        ckbit(0, 1'b1);
        wr(ARW_IDX_FLAGS, 8'h01);
        @(posedge mclk_i);
        ckbit(0, 1'b0);
        wr(ARW_IDX_MASK, 8'h00);
        samp(12'h010);
        ckbit(0, 1'b0);
        wr(ARW_IDX_FLAGS, 8'h03);
        rd(ARW_IDX_FLAGS, 32'h0);
        cpu_halted_i <= 1'b1;
        wr(ARW_IDX_DBG, 8'h00);
        @(posedge mclk_i);
        ckbit(1, 1'b0);
        pulse();
        ckbit(2, 1'b0);
        samp(12'h020);
        rd(ARW_IDX_FLAGS, 32'h0);
        wr(ARW_IDX_DBG, 8'h01);
        rd(ARW_IDX_DBG, 32'h1);
        @(posedge mclk_i);
        ckbit(1, 1'b1);
        pulse();
        ckbit(2, 1'b1);
        samp(12'h020);
        rd(ARW_IDX_FLAGS, 32'h1);
        cpu_halted_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        conclude();
    end
endmodule : adc_result_window_regs_tb_top
